// ### rtl/pdd_defines.svh
// Constants for the programmable decade divider
`ifndef PDD_DEFINES_SVH
`define PDD_DEFINES_SVH

// Decade positions in the cascade
`define PDD_NUM_DEC      3
`define PDD_UNITS        0
`define PDD_TENS         1
`define PDD_HUNDREDS     2

// BCD count values
`define PDD_BCD_ZERO     4'h0
`define PDD_BCD_ONE      4'h1
`define PDD_BCD_NINE     4'h9

// Reset values
`define PDD_RST_CNT      4'h0
`define PDD_RST_THOU     1'h0
`define PDD_RST_OUT      1'h0

`endif

// ### rtl/pdd_divider.sv
// Programmable divide-by-N counter built from cascaded decade down-counters
`include "pdd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - Each decade loads its BCD preset 0 to 9 on recycle, then counts down.
// R2 - Each clock event to a decade lowers its count by one.
// R3 - The units decade counts on each falling oscillator edge.
// R4 - A decade at zero raises its recycle request unless a later one holds low.
// R5 - With recycle request free, the event after zero reloads the preset.
// R6 - With recycle request held low, the event after zero loads nine.
// R7 - The last decade governs reload; earlier decades run one extra nine-to-zero cycle.
// R8 - Each zero-to-nine wrap makes a carry that clocks the next decade once.
// R9 - No decade reloads while any later recycle request is low.
// R10 - Oscillator pulses gate every decade and the final output gate.
// R11 - Hundreds wrap clocks the output flip-flop, gated with hundreds request.
// R12 - Output pulses only when gate and all recycle requests are high together.
// R13 - Presets come as BCD from weight eight, four, two and one inputs.
// R14 - The preset supplied equals station number plus 140.
// R15 - Output period equals preset count times oscillator period; a preset of zero gives one oscillator period.
// R16 - The reference compared against is a steady 1 ms pulse train.
// R17 - A synchronous init loads all presets, thousands into the output flip-flop, and clears the output.
// R18 - All events run on one clock with falling-edge detect on the oscillator.
module pdd_divider (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Oscillator pulse train and initialization
  input  wire logic       osc_pulse_in,
  input  wire logic       init,
  // BCD presets, bit 0 units, bit 1 tens, bit 2 hundreds
  input  wire logic [2:0] preset_weight_eight,
  input  wire logic [2:0] preset_weight_four,
  input  wire logic [2:0] preset_weight_two,
  input  wire logic [2:0] preset_weight_one,
  // Thousands preset held by the output flip-flop
  input  wire logic       thousands_preset,
  // Divided output and status
  output var  logic       divided_pulse_out,
  output var  logic       recycle_ready
);

  // Clocks one decade: wrap to nine with carry, else step down
  function automatic pdd_pkg::pdd_step_t dec_step(input pdd_pkg::pdd_bcd_t c);
    pdd_pkg::pdd_step_t r;
    r.carry = 1'b0;
    r.val   = c;
    if (c == `PDD_BCD_ZERO)
    begin
      r.carry = 1'b1;
      r.val   = `PDD_BCD_NINE;
    end
    else
    begin
      r.val   = c - `PDD_BCD_ONE;
    end
    return r;
  endfunction

  // Builds one decade preset from its weighted inputs
  function automatic pdd_pkg::pdd_bcd_t preset_of(input int unsigned i);
    preset_of = {preset_weight_eight[i], preset_weight_four[i],
                 preset_weight_two[i], preset_weight_one[i]};
  endfunction

  // State
  pdd_pkg::pdd_bcd_t  cnt      [0:`PDD_NUM_DEC-1];
  pdd_pkg::pdd_bcd_t  next_cnt [0:`PDD_NUM_DEC-1];
  logic               thou;
  logic               next_thou;
  logic               osc_q;
  logic               next_osc_q;
  logic               next_divided_pulse_out;
  logic               next_recycle_ready;

  // Decode
  logic               osc_fall;
  logic [2:0]         rr;
  logic               all_done;
  pdd_pkg::pdd_act_t  act;
  pdd_pkg::pdd_step_t st_u;
  pdd_pkg::pdd_step_t st_t;
  pdd_pkg::pdd_step_t st_h;
  pdd_pkg::pdd_bcd_t  preset_u;
  pdd_pkg::pdd_bcd_t  preset_t;
  pdd_pkg::pdd_bcd_t  preset_h;

  // Falling edge of the oscillator pulse train
  assign osc_fall = osc_q & ~osc_pulse_in; // R18

  // Recycle requests per decade, wired together as the cascade line
  assign rr[`PDD_UNITS]    = (cnt[`PDD_UNITS]    == `PDD_BCD_ZERO); // R4
  assign rr[`PDD_TENS]     = (cnt[`PDD_TENS]     == `PDD_BCD_ZERO); // R4
  assign rr[`PDD_HUNDREDS] = (cnt[`PDD_HUNDREDS] == `PDD_BCD_ZERO); // R4
  assign all_done = (&rr) & ~thou; // R7 R9 R11

  assign st_u = dec_step(cnt[`PDD_UNITS]);
  assign st_t = dec_step(cnt[`PDD_TENS]);
  assign st_h = dec_step(cnt[`PDD_HUNDREDS]);

  // Presets as seen on the weight inputs
  always_comb
  begin
    preset_u = preset_of(`PDD_UNITS); // R13
    preset_t = preset_of(`PDD_TENS);
    preset_h = preset_of(`PDD_HUNDREDS);
  end

  // Action for this cycle
  always_comb
  begin
    if (init)
      act = pdd_pkg::PDD_ACT_INIT; // R17
    else if (all_done && (osc_pulse_in || osc_fall))
      act = pdd_pkg::PDD_ACT_RELOAD; // R5 R7 R9
    else if (osc_fall)
      act = pdd_pkg::PDD_ACT_COUNT; // R3
    else
      act = pdd_pkg::PDD_ACT_HOLD;
  end

  // Next counter state
  always_comb
  begin
    for (int i = 0; i < `PDD_NUM_DEC; i++)
      next_cnt[i] = cnt[i];
    next_thou  = thou;
    next_osc_q = osc_pulse_in;
    case (act)
      pdd_pkg::PDD_ACT_INIT,
      pdd_pkg::PDD_ACT_RELOAD:
      begin
        for (int i = 0; i < `PDD_NUM_DEC; i++)
          next_cnt[i] = preset_of(i); // R1 R13
        next_thou = thousands_preset; // R17
      end
      pdd_pkg::PDD_ACT_COUNT:
      begin
        // Not all done, so a decade at zero wraps to nine
        next_cnt[`PDD_UNITS] = st_u.val; // R2 R6 R9
        if (st_u.carry)
        begin
          next_cnt[`PDD_TENS] = st_t.val; // R8
          if (st_t.carry)
          begin
            next_cnt[`PDD_HUNDREDS] = st_h.val; // R8
            if (st_h.carry)
              next_thou = 1'b0; // R11
          end
        end
      end
      pdd_pkg::PDD_ACT_HOLD:
      begin
        next_thou = thou;
      end
      default:
      begin
        next_thou = thou;
      end
    endcase
  end

  // Final output gate: oscillator high with every request released
  always_comb
  begin
    next_divided_pulse_out = osc_pulse_in & all_done & ~init; // R10 R12 R15
    next_recycle_ready     = all_done;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `PDD_NUM_DEC; i++)
        cnt[i] <= `PDD_RST_CNT;
      thou              <= `PDD_RST_THOU;
      osc_q             <= 1'b0;
      divided_pulse_out <= `PDD_RST_OUT;
      recycle_ready     <= 1'b0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < `PDD_NUM_DEC; i++)
        cnt[i] <= next_cnt[i];
      thou              <= next_thou;
      osc_q             <= next_osc_q;
      divided_pulse_out <= next_divided_pulse_out;
      recycle_ready     <= next_recycle_ready;
    end
  end

  // Checks
  property p_init_load;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && init) |=> (cnt[`PDD_UNITS] == $past(preset_u))
      && (cnt[`PDD_HUNDREDS] == $past(preset_h))
      && (thou == $past(thousands_preset));
  endproperty
  a_init_load: assert property (p_init_load) // R1 R17
    else $error("init did not load presets");

  property p_units_down;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall && !all_done && !rr[`PDD_UNITS])
      |=> cnt[`PDD_UNITS] == $past(cnt[`PDD_UNITS]) - `PDD_BCD_ONE;
  endproperty
  a_units_down: assert property (p_units_down) // R2
    else $error("units decade did not step down");

  property p_hold_no_edge;
    @(posedge clk) disable iff (!rst_n)
    (!init && !osc_fall && !(osc_pulse_in && all_done))
      |=> $stable(cnt[`PDD_UNITS]) && $stable(thou);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) // R3
    else $error("count moved without a falling edge");

  property p_wrap_nine;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall && !all_done && rr[`PDD_UNITS])
      |=> cnt[`PDD_UNITS] == `PDD_BCD_NINE;
  endproperty
  a_wrap_nine: assert property (p_wrap_nine) // R6 R9
    else $error("held decade did not load nine");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && all_done && osc_pulse_in)
      |=> (cnt[`PDD_TENS] == $past(preset_t)) && (cnt[`PDD_UNITS] == $past(preset_u));
  endproperty
  a_reload: assert property (p_reload) // R5 R7
    else $error("cascade did not reload");

  property p_carry_tens;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall && !all_done && rr[`PDD_UNITS] && !rr[`PDD_TENS])
      |=> cnt[`PDD_TENS] == $past(cnt[`PDD_TENS]) - `PDD_BCD_ONE;
  endproperty
  a_carry_tens: assert property (p_carry_tens) // R8
    else $error("units wrap did not clock tens");

  property p_thou_clock;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall && !all_done && (&rr)) |=> !thou;
  endproperty
  a_thou_clock: assert property (p_thou_clock) // R11
    else $error("hundreds wrap did not clock output flip-flop");

  property p_out_gate;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && osc_pulse_in && all_done && !init) ##1 1'b1 |-> divided_pulse_out;
  endproperty
  a_out_gate: assert property (p_out_gate) // R12
    else $error("gated output missing");

  property p_out_cause;
    @(posedge clk) disable iff (!rst_n)
    $rose(divided_pulse_out) |-> $past(all_done) && $past(osc_pulse_in);
  endproperty
  a_out_cause: assert property (p_out_cause) // R10 R15
    else $error("output pulse without gate and requests");

  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(cnt[`PDD_UNITS]) && $stable(cnt[`PDD_HUNDREDS]) && $stable(thou)
      && $stable(divided_pulse_out) && $stable(recycle_ready);
  endproperty
  a_freeze: assert property (p_freeze) // R18
    else $error("state moved while clock enable low");

  property p_ready_set;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && all_done) |=> recycle_ready;
  endproperty
  a_ready_set: assert property (p_ready_set) // R4 R12
    else $error("recycle ready missing at all zero");

  property p_ready_clear;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !all_done) |=> !recycle_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear) // R4 R9
    else $error("recycle ready while a decade is held");

  property p_tens_still;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall && !all_done && !rr[`PDD_UNITS])
      |=> $stable(cnt[`PDD_TENS]);
  endproperty
  a_tens_still: assert property (p_tens_still) // R8
    else $error("tens moved without a units wrap");

  property p_held_no_reload;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_pulse_in && !all_done)
      |=> $stable(cnt[`PDD_UNITS]) && $stable(cnt[`PDD_HUNDREDS]);
  endproperty
  a_held_no_reload: assert property (p_held_no_reload) // R9 R10
    else $error("decade reloaded while a request was held");

  property p_init_clear;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && init) |=> !divided_pulse_out;
  endproperty
  a_init_clear: assert property (p_init_clear) // R17
    else $error("init did not clear the output");

  property p_out_fall;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && !init && osc_fall) |=> !divided_pulse_out;
  endproperty
  a_out_fall: assert property (p_out_fall) // R10 R12
    else $error("output pulse while oscillator low");

endmodule : pdd_divider

`default_nettype wire

// ### rtl/pdd_pkg.sv
// Types for the programmable decade divider
package pdd_pkg;

  // One BCD digit
  typedef logic [3:0] pdd_bcd_t;

  // Result of clocking one decade
  typedef struct packed {
    logic     carry;
    pdd_bcd_t val;
  } pdd_step_t;

  // What the cascade does on one oscillator event
  typedef enum {
    PDD_ACT_HOLD,
    PDD_ACT_INIT,
    PDD_ACT_RELOAD,
    PDD_ACT_COUNT
  } pdd_act_t;

endpackage : pdd_pkg

// ### verification/pdd_osc_source.sv
// Oscillator pulse source feeding the divider
`timescale 1ns/1ps
`default_nettype none
module pdd_osc_source (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pulse train
  output var  logic osc
);
  int left;

  // Random phases of one to three cycles
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc  <= 1'h0;
      left <= 0;
    end
    else if (left == 0)
    begin
      osc  <= ~osc;
      left <= $urandom_range(2, 0);
    end
    else
      left <= left - 1;
  end
endmodule // pdd_osc_source
`default_nettype wire

// ### verification/programmable_decade_divider_bench.sv
// Self-checking bench for the decade divider
`timescale 1ns/1ps
`default_nettype none
module programmable_decade_divider_bench;
  logic       clk = 1'h0, rst_n = 1'h0, clk_en = 1'h0, init = 1'h0, thou = 1'h0;
  logic [2:0] w8 = 3'h0, w4 = 3'h0, w2 = 3'h0, w1 = 3'h0;
  wire logic  osc, dout, rdy;
  int         miscompares = 0, comparisons = 0, rem, gap = 0, nexp = 1;
  logic       prev, e_out, e_rdy, armed, dq;
  int         stn[3] = '{1094, 1490, 60};
  int         nv[8] = '{0, 1, 9, 10, 99, 100, 7, 25};

  pdd_divider uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .osc_pulse_in(osc),
    .init(init), .preset_weight_eight(w8), .preset_weight_four(w4),
    .preset_weight_two(w2), .preset_weight_one(w1), .thousands_preset(thou),
    .divided_pulse_out(dout), .recycle_ready(rdy));
  pdd_osc_source src (.clk(clk), .rst_n(rst_n), .osc(osc));

  initial forever #50 clk = ~clk;

  task automatic final_report;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic e, input logic s);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", nm, e, s);
    end
  endtask

  // Preset value seen on the weight inputs
  function automatic int preset_val();
    int v;
    v = thou * 1000;
    for (int i = 0; i < 3; i++)
      v += int'({w8[i], w4[i], w2[i], w1[i]}) * (10 ** i);
    return v;
  endfunction

  // Reference model: one pulse per N falling edges
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem = 0;
      gap = 0;
      nexp = 1;
      prev = 1'h0;
      armed = 1'h0;
      dq = 1'h0;
      e_out <= 1'h0;
      e_rdy <= 1'h0;
    end
    else
    begin
      // Falling edges seen between two output pulses
      if (dout && !dq && armed)
      begin
        comparisons++;
        if (gap != nexp)
        begin
          miscompares++;
          $display("FAIL pulse_spacing expected %0d seen %0d", nexp, gap);
        end
      end
      if (dout && !dq)
      begin
        gap = 0;
        armed = 1'h1;
      end
      dq = dout;
      if (clk_en)
      begin
        e_out <= osc && rem == 0 && !init;
        e_rdy <= rem == 0;
        if (prev && !osc)
          gap++;
        if (init)
        begin
          rem = preset_val();
          nexp = (rem == 0) ? 1 : rem;
          armed = 1'h0;
        end
        else if (rem == 0 && (osc || prev))
          rem = preset_val();
        else if (prev && !osc)
          rem = rem - 1;
        prev = osc;
      end
    end
  end

  always @(negedge clk)
  begin
    if (rst_n)
    begin
      check("divided_pulse_out", e_out, dout);
      check("recycle_ready", e_rdy, rdy);
    end
  end

  task automatic run(input int n, input int cyc);
    int d;
    @(posedge clk);
    thou <= n >= 1000;
    for (int i = 0; i < 3; i++)
    begin
      d = (n / (10 ** i)) % 10;
      w8[i] <= d[3];
      w4[i] <= d[2];
      w2[i] <= d[1];
      w1[i] <= d[0];
    end
    clk_en <= 1'h1;
    init   <= 1'h1;
    @(posedge clk);
    init <= 1'h0;
    repeat (cyc) @(posedge clk) clk_en <= $urandom_range(7, 0) != 0;
  endtask

  initial
  begin
    #(80000 * 100);
    miscompares++;
    final_report();
  end

  initial
  begin
    void'($urandom(97));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    foreach (stn[i]) run(stn[i] + 140, (stn[i] + 140) * 12 + 60);
    foreach (nv[i]) run(nv[i], nv[i] * 12 + 60);
    run(1234, 300);
    @(posedge clk) rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    run(25, 400);
    final_report();
  end
endmodule // programmable_decade_divider_bench
`default_nettype wire
